//--- core/iod_pkg.sv
// package: map, opcodes and reserved-address decode for the i/o space decoder
package iod_pkg;

	// address map, data-space view
	localparam logic [7:0] IO_DATA_OFS    = 8'h20;
	localparam logic [7:0] EXT_DATA_FIRST = 8'h60;
	localparam int         BIT_ADDR_MSB   = 5;
	localparam int         PORT_ADDR_W    = 6;

	// core register i/o addresses
	localparam logic [7:0] SCRATCH_REG_1_IO  = 8'h2A;
	localparam logic [7:0] SCRATCH_REG_2_IO  = 8'h2B;
	localparam logic [7:0] STACK_PTR_LOW_IO  = 8'h3D;
	localparam logic [7:0] STACK_PTR_HIGH_IO = 8'h3E;
	localparam logic [7:0] CORE_FLAGS_REG_IO = 8'h3F;

	// core register storage
	localparam int         NUM_CORE_REGS = 5;
	localparam logic [2:0] IDX_SCRATCH_1 = 3'h0;
	localparam logic [2:0] IDX_SCRATCH_2 = 3'h1;
	localparam logic [2:0] IDX_SP_LOW    = 3'h2;
	localparam logic [2:0] IDX_SP_HIGH   = 3'h3;
	localparam logic [2:0] IDX_FLAGS     = 3'h4;
	localparam logic [7:0] CORE_REG_RST  = 8'h00;
	localparam logic [7:0] RSV_READ_VAL  = 8'h00;

	// access kinds; direct and displacement memory forms decode as the plain ones
	typedef enum logic [2:0] {
		PORT_READ_OP     = 3'h0,
		PORT_WRITE_OP    = 3'h1,
		MEM_READ_OP      = 3'h2,
		MEM_WRITE_OP     = 3'h3,
		BIT_SET_OP       = 3'h4,
		BIT_CLEAR_OP     = 3'h5,
		SKIP_IF_BIT_ONE  = 3'h6,
		SKIP_IF_BIT_ZERO = 3'h7
	} iod_op_e;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_READ  = 3'b010,
		S_WRITE = 3'b100
	} iod_state_e;

	// reserved locations, by data address 0x20..0xFF
	function automatic logic iod_is_reserved(input logic [7:0] da);
		iod_is_reserved = da inside {[8'h2C:8'h34], [8'h38:8'h3A], 8'h49, 8'h4F, 8'h52,
			8'h56, [8'h58:8'h5C], 8'h62, 8'h63, 8'h65, 8'h67, 8'h6A, 8'h71, 8'h72,
			[8'h74:8'h77], 8'h7D, 8'h83, [8'h8C:8'hAF], 8'hB5, 8'hB7, 8'hBE, 8'hBF,
			8'hC3, 8'hC7, 8'hCB, [8'hCF:8'hFF]};
	endfunction

endpackage

//--- core/iod_core_regs.sv
// core register file: scratch, stack pointer and core flags
`timescale 1ns/1ps
`default_nettype none
module iod_core_regs
	import iod_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	// access from the decoder
	input  wire logic       wr_en_i,
	input  wire logic [2:0] idx_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	// core side
	input  wire logic       flags_upd_i,
	input  wire logic [7:0] flags_i,
	output logic      [15:0] sp_o,
	output logic      [7:0] flags_o
);

	logic [7:0] regs_ff [NUM_CORE_REGS];

	generate
		for (genvar g = 0; g < NUM_CORE_REGS; g++) begin : g_reg
			// a software write beats a same-cycle flag update from the alu
			wire logic hit = wr_en_i && (idx_i == 3'(g));
			wire logic upd = flags_upd_i && (3'(g) == IDX_FLAGS);
			always_ff @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i)
					regs_ff[g] <= CORE_REG_RST;
				else if (hit)
					regs_ff[g] <= wdata_i; // see RQ10
				else if (upd)
					regs_ff[g] <= flags_i;
			end
		end
	endgenerate

	assign rdata_o = (idx_i < 3'(NUM_CORE_REGS)) ? regs_ff[idx_i] : RSV_READ_VAL;
	assign sp_o    = {regs_ff[IDX_SP_HIGH], regs_ff[IDX_SP_LOW]};
	assign flags_o = regs_ff[IDX_FLAGS];

endmodule
`default_nettype wire

//--- core/iod_decoder.sv
// i/o space access decoder: routes core i/o and load/store accesses
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: software writes zero to reserved bit positions of any register.
// RQ2: software never writes a reserved i/o address.
// RQ3: bit set and clear work on i/o addresses 0x00..0x1F only.
// RQ4: skip-if-bit-one and skip-if-bit-zero test any bit of low-region registers.
// RQ5: flags clear on a written one; a written zero leaves them unchanged.
// RQ6: bit set/clear reads the whole register, then writes all bits back.
// RQ7: port read and write use a six-bit field, i/o 0x00..0x3F.
// RQ8: load/store reach i/o registers at data address i/o plus 0x20.
// RQ9: extended region from 0x60 is reachable by load and store only.
// RQ10: scratch registers hold the last byte written and return it.
// RQ11: reserved addresses and bit positions read as zero.
module iod_decoder
	import iod_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	// core request
	input  wire logic       req_i,
	input  wire iod_op_e    op_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [2:0] bit_i,
	input  wire logic [7:0] wdata_i,
	// core answer
	output logic            ready_o,
	output logic            done_o,
	output logic      [7:0] rdata_o,
	output logic            skip_o,
	output logic            err_o,
	// peripheral register bus
	output logic      [7:0] per_addr_o,
	output logic            per_rd_o,
	output logic            per_wr_o,
	output logic      [7:0] per_wdata_o,
	input  wire logic [7:0] per_rdata_i,
	// core state
	input  wire logic       flags_upd_i,
	input  wire logic [7:0] flags_i,
	output logic      [15:0] sp_o,
	output logic      [7:0] flags_o
);

	////////////////////////////////////////////////////////////////////////////////
	// request classification

	iod_state_e state_ff;
	iod_state_e nxt_state;
	iod_op_e    op_ff;
	logic [7:0] da_ff;
	logic [2:0] bit_ff;
	logic [7:0] wdata_ff;
	logic       done_ff;
	logic [7:0] rdata_ff;
	logic       skip_ff;
	logic       err_ff;

	wire logic       accept   = req_i && ready_o;
	wire logic       is_bit   = op_i inside {BIT_SET_OP, BIT_CLEAR_OP,
		SKIP_IF_BIT_ONE, SKIP_IF_BIT_ZERO};
	wire logic       is_mem   = op_i inside {MEM_READ_OP, MEM_WRITE_OP};
	wire logic       is_wr    = op_i inside {PORT_WRITE_OP, MEM_WRITE_OP};
	// port ops carry only six address bits, so they cannot reach 0x60 and up
	wire logic [7:0] port_da  = {2'b00, addr_i[PORT_ADDR_W-1:0]} + IO_DATA_OFS; // see RQ7
	wire logic [7:0] addr_lo  = addr_i[7:0];
	wire logic       mem_io   = (addr_i[15:8] == 8'h00) && (addr_lo >= IO_DATA_OFS); // see RQ9
	wire logic [7:0] req_da   = is_mem ? addr_lo : port_da; // see RQ8
	wire logic       req_bad  = is_bit ? addr_i[BIT_ADDR_MSB] : (is_mem && !mem_io); // see RQ3

	////////////////////////////////////////////////////////////////////////////////
	// target decode of the latched access

	wire logic [7:0] io_ofs   = da_ff - IO_DATA_OFS;
	wire logic       int_hit  = io_ofs inside {SCRATCH_REG_1_IO, SCRATCH_REG_2_IO,
		STACK_PTR_LOW_IO, STACK_PTR_HIGH_IO, CORE_FLAGS_REG_IO};
	wire logic [2:0] int_idx  = (io_ofs == SCRATCH_REG_1_IO)  ? IDX_SCRATCH_1 :
	                            (io_ofs == SCRATCH_REG_2_IO)  ? IDX_SCRATCH_2 :
	                            (io_ofs == STACK_PTR_LOW_IO)  ? IDX_SP_LOW :
	                            (io_ofs == STACK_PTR_HIGH_IO) ? IDX_SP_HIGH : IDX_FLAGS;
	wire logic       rsv_hit  = iod_is_reserved(da_ff);
	wire logic       ext_hit  = !int_hit && !rsv_hit;
	wire logic       is_rmw   = op_ff inside {BIT_SET_OP, BIT_CLEAR_OP};
	wire logic [7:0] bit_mask = 8'(8'h01 << bit_ff);
	logic [7:0] core_rdata;
	wire logic [7:0] rd_val   = int_hit ? core_rdata :
	                            rsv_hit ? RSV_READ_VAL : per_rdata_i; // see RQ11
	// the whole byte goes back, so set one-to-clear flags read as one get cleared
	wire logic [7:0] rmw_val  = (op_ff == BIT_SET_OP) ? (rd_val | bit_mask) :
	                                                    (rd_val & ~bit_mask); // see RQ6
	wire logic       sel_bit  = rd_val[bit_ff];
	wire logic       skip_val = (op_ff == SKIP_IF_BIT_ONE)  ? sel_bit :
	                            (op_ff == SKIP_IF_BIT_ZERO) ? !sel_bit : 1'b0; // see RQ4
	wire logic       in_read  = (state_ff == S_READ);
	wire logic       in_write = (state_ff == S_WRITE);

	assign ready_o     = (state_ff == S_IDLE);
	assign per_addr_o  = da_ff;
	assign per_rd_o    = in_read && ext_hit;
	// reserved locations never see a write strobe
	assign per_wr_o    = in_write && ext_hit; // see RQ2
	// written zeros stay zeros, so flags behind them are left alone
	assign per_wdata_o = wdata_ff; // see RQ5
	assign done_o      = done_ff;
	assign rdata_o     = rdata_ff;
	assign skip_o      = skip_ff;
	assign err_o       = err_ff;

	////////////////////////////////////////////////////////////////////////////////
	// sequencing

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			S_IDLE: begin
				if (accept && !req_bad)
					nxt_state = is_wr ? S_WRITE : S_READ;
			end
			S_READ:  nxt_state = is_rmw ? S_WRITE : S_IDLE; // see RQ6
			S_WRITE: nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= S_IDLE;
			op_ff    <= PORT_READ_OP;
			da_ff    <= 8'h00;
			bit_ff   <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			if (accept) begin
				op_ff  <= op_i;
				da_ff  <= req_da;
				bit_ff <= bit_i;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			wdata_ff <= 8'h00;
		else if (accept)
			wdata_ff <= wdata_i;
		else if (in_read && is_rmw)
			wdata_ff <= rmw_val;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done_ff  <= 1'b0;
			rdata_ff <= 8'h00;
			skip_ff  <= 1'b0;
			err_ff   <= 1'b0;
		end else begin
			done_ff <= (in_read && !is_rmw) || in_write || (accept && req_bad);
			err_ff  <= accept && req_bad; // see RQ3
			skip_ff <= in_read && skip_val;
			if (in_read && !is_rmw)
				rdata_ff <= rd_val;
		end
	end

	iod_core_regs u_core_regs (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.wr_en_i     (in_write && int_hit),
		.idx_i       (int_idx),
		.wdata_i     (wdata_ff),
		.rdata_o     (core_rdata),
		.flags_upd_i (flags_upd_i),
		.flags_i     (flags_i),
		.sp_o        (sp_o),
		.flags_o     (flags_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	logic [7:0] shadow1_ff;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			shadow1_ff <= CORE_REG_RST;
		else if (in_write && (io_ofs == SCRATCH_REG_1_IO))
			shadow1_ff <= wdata_ff;
	end

	bitop_range_a: assert property ( // see RQ3
		accept && is_bit && addr_i[BIT_ADDR_MSB] |=> done_o && err_o && ready_o
	) else $error("bit op above 0x1F was not refused");

	skip_test_a: assert property ( // see RQ4
		in_read && (op_ff == SKIP_IF_BIT_ZERO) |=> done_o && (skip_o == !$past(sel_bit))
	) else $error("skip-if-zero result wrong");

	w1c_pass_a: assert property ( // see RQ5
		accept && (op_i == PORT_WRITE_OP) |=> (per_wdata_o == $past(wdata_i)) ##1 done_o
	) else $error("port write data altered");

	rmw_seq_a: assert property ( // see RQ6
		per_rd_o && (op_ff == BIT_SET_OP) |=> per_wr_o && (per_addr_o == $past(per_addr_o))
			&& (per_wdata_o == ($past(per_rdata_i) | $past(bit_mask)))
	) else $error("bit set did not write back the read byte");

	port_map_a: assert property ( // see RQ7
		accept && (op_i == PORT_READ_OP) |=> (per_addr_o == $past(port_da))
			&& (per_addr_o >= IO_DATA_OFS) && (per_addr_o < EXT_DATA_FIRST)
	) else $error("port address outside 0x20..0x5F");

	mem_map_a: assert property ( // see RQ8
		accept && is_mem && !req_bad |=> per_addr_o == $past(addr_lo)
	) else $error("load/store data address mangled");

	port_no_ext_a: assert property ( // see RQ9
		(per_rd_o || per_wr_o) && (op_ff inside {PORT_READ_OP, PORT_WRITE_OP})
			|-> per_addr_o < EXT_DATA_FIRST
	) else $error("port op reached extended region");

	scratch_hold_a: assert property ( // see RQ10
		in_read && !is_rmw && (io_ofs == SCRATCH_REG_1_IO) |=> rdata_o == shadow1_ff
	) else $error("scratch register lost its byte");

	rsv_zero_a: assert property ( // see RQ11
		in_read && rsv_hit && !is_rmw |-> !per_rd_o ##1 (done_o && rdata_o == RSV_READ_VAL)
	) else $error("reserved read not zero");

	rsv_nowr_a: assert property ( // see RQ2
		per_wr_o |-> !iod_is_reserved(per_addr_o) && !int_hit
	) else $error("write strobe on reserved address");

endmodule
`default_nettype wire

//--- testbench/iod_periph_model.sv
// peripheral register space model on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module iod_periph_model (
	// clock
	input  wire logic       mclk_i,
	// peripheral bus
	input  wire logic [7:0] addr_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem_ff [256];
	initial begin
		for (int i = 0; i < 256; i++) mem_ff[i] = (i == 8'h35) ? 8'h07 : 8'(i) ^ 8'h5A;
	end
	// an idle bus shows the inverse, so a stale byte never passes for a read
	assign rdata_o = rd_i ? mem_ff[addr_i] : ~mem_ff[addr_i];
	always @(posedge mclk_i) begin
		if (wr_i && addr_i == 8'h35) mem_ff[addr_i] <= mem_ff[addr_i] & ~wdata_i;
		else if (wr_i) mem_ff[addr_i] <= wdata_i;
	end
endmodule
`default_nettype wire

//--- testbench/io_space_access_decoder_bench.sv
// self-checking bench for the i/o space decoder
`timescale 1ns/1ps
`default_nettype none
module io_space_access_decoder_bench;
	import iod_pkg::*;
	logic        mclk_i, reset_n_i, req_i, flags_upd_i;
	iod_op_e     op_i;
	logic [15:0] addr_i, sp_o;
	logic [2:0]  bit_i;
	logic [7:0]  wdata_i, rdata_o, per_addr_o, per_wdata_o, per_rdata_i, flags_i, flags_o;
	logic        ready_o, done_o, skip_o, err_o, per_rd_o, per_wr_o;
	int          fails, total_checks, cyc, lat;
	logic [7:0]  rm [256];
	logic        r_s, r_e;
	logic [7:0]  r_d;
	integer      seed = 32'hebe8a229;
	iod_decoder dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i), .op_i(op_i),
		.addr_i(addr_i), .bit_i(bit_i), .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o),
		.rdata_o(rdata_o), .skip_o(skip_o), .err_o(err_o), .per_addr_o(per_addr_o),
		.per_rd_o(per_rd_o), .per_wr_o(per_wr_o), .per_wdata_o(per_wdata_o),
		.per_rdata_i(per_rdata_i), .flags_upd_i(flags_upd_i), .flags_i(flags_i), .sp_o(sp_o),
		.flags_o(flags_o));
	iod_periph_model periph (.mclk_i(mclk_i), .addr_i(per_addr_o), .rd_i(per_rd_o),
		.wr_i(per_wr_o), .wdata_i(per_wdata_o), .rdata_o(per_rdata_i));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reference: reserved places 0x2C..0x34 and 0xCF..0xFF read as zero, one flag register clears on ones
	function automatic logic [7:0] rv(input logic [7:0] da);
		return (da inside {[8'h2C:8'h34], [8'hCF:8'hFF]}) ? 8'h00 : rm[da];
	endfunction
	function automatic void rwr(input logic [7:0] da, input logic [7:0] w);
		if (da == 8'h35) rm[da] = rm[da] & ~w;
		else rm[da] = w;
	endfunction
	task automatic run(input iod_op_e op, input logic [15:0] a, input logic [2:0] b,
		input logic [7:0] w);
		logic       mem, bop, bad;
		logic [7:0] da, cur;
		mem = op inside {MEM_READ_OP, MEM_WRITE_OP};
		bop = op inside {BIT_SET_OP, BIT_CLEAR_OP, SKIP_IF_BIT_ONE, SKIP_IF_BIT_ZERO};
		bad = (bop && a[5]) || (mem && (a < 16'h0020 || a > 16'h00FF));
		da = mem ? a[7:0] : {2'b00, a[5:0]} + 8'h20;
		@(posedge mclk_i) #1;
		req_i = 1'b1;
		op_i = op;
		addr_i = a;
		bit_i = b;
		wdata_i = w;
		@(posedge mclk_i) #1;
		req_i = 1'b0;
		chk(16'(ready_o), 16'(bad));
		lat = 0;
		do begin
			if (lat > 0) @(posedge mclk_i) #1;
			lat++;
		end while (done_o !== 1'b1 && lat < 8);
		r_d = rdata_o;
		r_s = skip_o;
		r_e = err_o;
		chk(16'(lat), bad ? 16'h1 : (op inside {BIT_SET_OP, BIT_CLEAR_OP}) ? 16'h3 : 16'h2);
		chk(16'(r_e), 16'(bad));
		// a function result cannot be bit-selected, so hold it first
		cur = rv(da);
		if (!bad) begin
			case (op)
				PORT_READ_OP, MEM_READ_OP: chk(16'(r_d), 16'(cur));
				PORT_WRITE_OP, MEM_WRITE_OP: rwr(da, w);
				BIT_SET_OP: rwr(da, cur | (8'h01 << b));
				BIT_CLEAR_OP: rwr(da, cur & ~(8'h01 << b));
				SKIP_IF_BIT_ONE: chk(16'(r_s), 16'(cur[b]));
				default: chk(16'(r_s), 16'(!cur[b]));
			endcase
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] io, v;
		cyc = 0;
		{req_i, flags_upd_i, addr_i, bit_i, wdata_i, flags_i} = '0;
		op_i = PORT_READ_OP;
		for (int i = 0; i < 256; i++) rm[i] = (i == 8'h35) ? 8'h07 : 8'(i) ^ 8'h5A;
		foreach (rm[i]) if (i inside {8'h4A, 8'h4B, 8'h5D, 8'h5E, 8'h5F}) rm[i] = 8'h00;
		reset_n_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		chk({sp_o[7:0], flags_o}, 16'h0000);
		chk(16'({ready_o, done_o, skip_o, err_o, per_rd_o, per_wr_o, rdata_o}), 16'h2000);
		run(PORT_READ_OP, 16'h003F, 3'h0, 8'h00);
		// scratch and stack pointer bytes, upper address bits ignored by port ops
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			io = (i < 2) ? 8'h2A + 8'(i) : 8'h3B + 8'(i);
			run(PORT_WRITE_OP, {10'($random(seed)), io[5:0]}, 3'h0, v);
			run(MEM_READ_OP, 16'(io) + 16'h20, 3'h0, 8'h00);
		end
		chk(sp_o, {rm[8'h5E], rm[8'h5D]});
		v = 8'($random(seed));
		flags_upd_i = 1'b1;
		flags_i = v;
		@(posedge mclk_i) #1 flags_upd_i = 1'b0;
		rm[8'h5F] = v;
		chk(16'(flags_o), 16'(v));
		// every access kind against ordinary places, load and store also against extended ones
		for (int k = 0; k < 64; k++) begin
			io = 8'($unsigned($random(seed)) % 12);
			v = 8'($random(seed));
			if (k[5:3] inside {3'h2, 3'h3}) run(iod_op_e'(k[5:3]),
				k[0] ? 16'h0060 + 16'(io[0]) : 16'(io) + 16'h20, 3'h0, v);
			else run(iod_op_e'(k[5:3]), {10'($random(seed)), io[5:0]}, v[2:0], v);
		end
		// a reset in mid-run brings the core registers back to zero
		@(posedge mclk_i) #1 reset_n_i = 1'b0;
		@(posedge mclk_i) #1 reset_n_i = 1'b1;
		foreach (rm[i]) if (i inside {8'h4A, 8'h4B, 8'h5D, 8'h5E, 8'h5F}) rm[i] = 8'h00;
		chk(sp_o, 16'h0000);
		chk(16'({ready_o, done_o, skip_o, err_o, per_rd_o, per_wr_o, rdata_o}), 16'h2000);
		run(MEM_READ_OP, 16'h004B, 3'h0, 8'h00);
		run(PORT_READ_OP, 16'h003F, 3'h0, 8'h00);
		// read-modify-write clears a flag that reads as set
		run(BIT_SET_OP, 16'h0015, 3'h4, 8'h00);
		run(PORT_READ_OP, 16'h0015, 3'h0, 8'h00);
		run(BIT_CLEAR_OP, 16'h0020, 3'h1, 8'h00);
		run(SKIP_IF_BIT_ONE, 16'h003F, 3'h0, 8'h00);
		run(MEM_READ_OP, 16'h001F, 3'h0, 8'h00);
		run(MEM_WRITE_OP, 16'h0100, 3'h0, 8'hA5);
		run(PORT_READ_OP, 16'h000C, 3'h0, 8'h00);
		run(MEM_READ_OP, 16'h00D0, 3'h0, 8'h00);
		// software never writes reserved places here
		results();
	end
endmodule
`default_nettype wire
